// [core/kbrf_cfg.svh]
// Address map, reset values and program map limits of the keyboard register file
`ifndef KBRF_CFG_SVH
`define KBRF_CFG_SVH
`define KBRF_PORT0_ADDR     8'h00
`define KBRF_PORT1_ADDR     8'h01
`define KBRF_PORT2_ADDR     8'h02
`define KBRF_PORT3_ADDR     8'h03
`define KBRF_GPR_LO         8'h04
`define KBRF_GPR_HI         8'hbf
`define KBRF_CTL_LO         8'hf0
`define KBRF_P2MODE_ADDR    8'hf6
`define KBRF_IRQEN_ADDR     8'hfb
`define KBRF_RP_ADDR        8'hfd
`define KBRF_UNIMP_VALUE    8'hff
`define KBRF_PORT_RST       8'hff
`define KBRF_P2MODE_RST     8'hff
`define KBRF_IRQEN_RST      8'h00
`define KBRF_RP_RST         8'h00
`define KBRF_GPR_COUNT      188
`define KBRF_CTL_COUNT      16
`define KBRF_VEC_END        16'h000c
`define KBRF_ROM_TOP        16'h0fff
`endif

// [core/kbrf_core.sv]
// Register file, program memory map and I/O ports of the keyboard controller
`include "kbrf_cfg.svh"
module kbrf_core #(
  parameter logic [15:0] ROM_TOP = `KBRF_ROM_TOP
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        stop_recovery,
  input  wire logic        test_clock_enable,
  // Register access from the CPU
  input  wire logic        reg_wr,
  input  wire logic        reg_short,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic      [7:0]  reg_resolved,
  // Program fetch
  input  wire logic [15:0] fetch_pc,
  output logic      [1:0]  fetch_kind,
  output logic             fetch_valid,
  // Pins
  output logic      [7:0]  first_open_drain_port_oe_n,
  output logic      [7:0]  second_open_drain_port_oe_n,
  input  wire logic [7:0]  mixed_direction_port_in,
  output logic      [7:0]  mixed_direction_port_out,
  output logic      [7:0]  mixed_direction_port_oe_n,
  input  wire logic [3:0]  port3_fixed_inputs,
  output logic      [3:0]  port3_fixed_outputs,
  output logic      [3:0]  external_interrupt_requests,
  output logic             test_clock_output
);
  kbrf_pm_if pm ();  // Fetch path to the decoder

  // Program map decoder
  kbrf_pm_map #(.ROM_TOP(ROM_TOP)) u_map (.pm(pm));
  assign pm.pc       = fetch_pc;
  assign fetch_kind  = pm.kind;
  assign fetch_valid = pm.rom_hit;

  // Working register resolution: group bits above the operand
  function automatic logic [7:0] resolve(input logic [7:0] rp, input logic [7:0] a,
                                         input logic s);
    resolve = s ? {rp[7:4], a[3:0]} : a;
  endfunction

  // Address class helpers
  function automatic logic is_gpr(input logic [7:0] a);
    is_gpr = (a >= `KBRF_GPR_LO) && (a <= `KBRF_GPR_HI);
  endfunction

  logic [7:0] p0_q, p0_d;      // Port 0 latch
  logic [7:0] p1_q, p1_d;      // Port 1 latch
  logic [7:0] p2_q, p2_d;      // Port 2 output latch
  logic [3:0] p3_q, p3_d;      // Port 3 output latch
  logic [7:0] p2m_q, p2m_d;    // Port 2 direction, 1 = input
  logic [7:0] irqen_q, irqen_d; // Port 3 interrupt enables
  logic [7:0] rp_q, rp_d;      // Register pointer
  logic [7:0] gpr_q [`KBRF_GPR_COUNT];  // General registers
  logic [7:0] p2_s1_q, p2_s2_q;         // Port 2 synchroniser
  logic [3:0] p3_s1_q, p3_s2_q;         // Port 3 synchroniser
  logic [3:0] p3_prev_q;                // Edge detect history
  logic       tce_s1_q, tce_s2_q;       // Test strap synchroniser
  logic [7:0] addr;                     // Resolved address

  assign addr         = resolve(rp_q, reg_addr, reg_short);
  assign reg_resolved = addr;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    p2_s1_q   <= mixed_direction_port_in;
    p2_s2_q   <= p2_s1_q;
    p3_s1_q   <= port3_fixed_inputs;
    p3_s2_q   <= p3_s1_q;
    tce_s1_q  <= test_clock_enable;
    tce_s2_q  <= tce_s1_q;
    p3_prev_q <= rst ? 4'hf : p3_s2_q;
  end

  // Next values of the control and port registers
  always_comb begin
    p0_d = p0_q;
    p1_d = p1_q;
    p2_d = p2_q;
    p3_d = p3_q;
    p2m_d = p2m_q;
    irqen_d = irqen_q;
    rp_d = rp_q;
    if (reg_wr) begin
      case (addr)
        `KBRF_PORT0_ADDR:  p0_d = reg_wdata;
        `KBRF_PORT1_ADDR:  p1_d = reg_wdata;
        `KBRF_PORT2_ADDR:  p2_d = reg_wdata;
        `KBRF_PORT3_ADDR:  p3_d = reg_wdata[7:4];
        `KBRF_P2MODE_ADDR: p2m_d = {reg_wdata[7:4], 4'hf};
        `KBRF_IRQEN_ADDR:  irqen_d = {4'h0, reg_wdata[3:0]};
        `KBRF_RP_ADDR:     rp_d = reg_wdata;
        default: ;  // Unimplemented writes vanish
      endcase
    end
  end

  // Registers; pointer and GPRs kept across stop recovery
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      p0_q    <= `KBRF_PORT_RST;
      p1_q    <= `KBRF_PORT_RST;
      p2_q    <= `KBRF_PORT_RST;
      p3_q    <= 4'hf;
      p2m_q   <= `KBRF_P2MODE_RST;
      irqen_q <= `KBRF_IRQEN_RST;
      rp_q    <= `KBRF_RP_RST;
    end else if (stop_recovery) begin
      // Ports and modes reinitialised, pointer retained
      p0_q    <= `KBRF_PORT_RST;
      p1_q    <= `KBRF_PORT_RST;
      p2_q    <= `KBRF_PORT_RST;
      p3_q    <= 4'hf;
      p2m_q   <= `KBRF_P2MODE_RST;
      irqen_q <= `KBRF_IRQEN_RST;
      rp_q    <= rp_q;
    end else begin
      p0_q    <= p0_d;
      p1_q    <= p1_d;
      p2_q    <= p2_d;
      p3_q    <= p3_d;
      p2m_q   <= p2m_d;
      irqen_q <= irqen_d;
      rp_q    <= rp_d;
    end
  end

  // General registers: no reset, so contents survive recovery
  always_ff @(posedge clk_sys) begin
    if (reg_wr && is_gpr(addr)) begin
      gpr_q[addr - `KBRF_GPR_LO] <= reg_wdata;
    end
  end

  // Read multiplexer
  always_comb begin
    reg_rdata = `KBRF_UNIMP_VALUE;
    if (is_gpr(addr)) begin
      reg_rdata = gpr_q[addr - `KBRF_GPR_LO];
    end else begin
      case (addr)
        `KBRF_PORT0_ADDR:  reg_rdata = p0_q;
        `KBRF_PORT1_ADDR:  reg_rdata = p1_q;
        // Input lines show the pin, outputs their latch
        `KBRF_PORT2_ADDR:  reg_rdata = (p2_s2_q & p2m_q) | (p2_q & ~p2m_q);
        `KBRF_PORT3_ADDR:  reg_rdata = {p3_q, p3_s2_q};
        `KBRF_IRQEN_ADDR:  reg_rdata = irqen_q;
        `KBRF_RP_ADDR:     reg_rdata = rp_q;
        default:           reg_rdata = `KBRF_UNIMP_VALUE;
      endcase
    end
  end

  // Open drain: enable low pulls the line low
  assign first_open_drain_port_oe_n  = p0_q;
  assign second_open_drain_port_oe_n = p1_q;
  assign mixed_direction_port_out    = p2_q;
  // Lines 3..0 never driven
  assign mixed_direction_port_oe_n   = p2m_q | 8'h0f;
  assign port3_fixed_outputs         = p3_q;
  // Falling edge on enabled input raises a request pulse
  always_ff @(posedge clk_sys) begin
    external_interrupt_requests <= rst ? 4'h0 : (p3_prev_q & ~p3_s2_q & irqen_q[3:0]);
  end
  // Test clock only when strapped on; the strap is meant to stay put,
  // since a change close to a rising edge can clip one high phase
  assign test_clock_output = clk_sys & tce_s2_q;

  // Pointer keeps its value through stop recovery
  chk_rp_retained : assert property (@(posedge clk_sys) disable iff (rst)
    stop_recovery |=> rp_q == $past(rp_q)) else $error("pointer lost");
  // Short operand lands inside the pointer's group
  chk_short_group : assert property (@(posedge clk_sys) disable iff (rst)
    reg_short |-> reg_resolved[7:4] == rp_q[7:4] && reg_resolved[3:0] == reg_addr[3:0])
    else $error("bad working register");
  // Low port 2 lines never driven
  chk_p2_inputs : assert property (@(posedge clk_sys) disable iff (rst)
    mixed_direction_port_oe_n[3:0] == 4'hf) else $error("input line driven");
  // Unimplemented hole reads constant
  chk_hole_read : assert property (@(posedge clk_sys) disable iff (rst)
    (addr > `KBRF_GPR_HI && addr < `KBRF_CTL_LO) |-> reg_rdata == `KBRF_UNIMP_VALUE)
    else $error("hole not constant");
  // Port 0 write reaches pins next cycle
  chk_p0_write : assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && addr == `KBRF_PORT0_ADDR && !stop_recovery)
    |=> first_open_drain_port_oe_n == $past(reg_wdata)) else $error("port0 stale");
  // Port 1 write reaches pins next cycle
  chk_p1_write : assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && addr == `KBRF_PORT1_ADDR && !stop_recovery)
    |=> second_open_drain_port_oe_n == $past(reg_wdata)) else $error("port1 stale");
  // Vector area covers bytes 0..11
  chk_vector_area : assert property (@(posedge clk_sys) disable iff (rst)
    (fetch_pc < `KBRF_VEC_END) |-> fetch_kind == kbrf_pkg::KBRF_PM_VECTOR)
    else $error("vector decode");
  // Request needs an enabled line
  chk_irq_enable : assert property (@(posedge clk_sys) disable iff (rst)
    (external_interrupt_requests & ~$past(irqen_q[3:0])) == 4'h0)
    else $error("masked request");
  // A request lasts one cycle only, so a held low line asks once
  chk_irq_single : assert property (@(posedge clk_sys) disable iff (rst)
    (external_interrupt_requests & $past(external_interrupt_requests)) == 4'h0)
    else $error("request stuck");
  // Mode write sets the drive of lines 7..4 next cycle, low lines stay released
  chk_p2_mode_write : assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && addr == `KBRF_P2MODE_ADDR && !stop_recovery)
    |=> mixed_direction_port_oe_n == {$past(reg_wdata[7:4]), 4'hf})
    else $error("mode stale");
endmodule

// [core/kbrf_pkg.sv]
// Types shared by the keyboard register file modules
package kbrf_pkg;
  typedef logic [7:0] kbrf_addr_t;  // Register file address
  typedef logic [7:0] kbrf_byte_t;  // Register data
  typedef logic [15:0] kbrf_pc_t;   // Program address
  // Kind of a program address
  typedef enum logic [1:0] {
    KBRF_PM_VECTOR   = 2'b00,
    KBRF_PM_ROM      = 2'b01,
    KBRF_PM_RESERVED = 2'b11
  } kbrf_pm_e;
endpackage

// [core/kbrf_pm_if.sv]
// Program fetch request and classification between core and map decoder
interface kbrf_pm_if;
  logic              [15:0] pc;         // Program counter value
  kbrf_pkg::kbrf_pm_e       kind;       // Region of that address
  logic                     rom_hit;    // Address is fetchable
  modport core (output pc, input kind, input rom_hit);
  modport map  (input pc, output kind, output rom_hit);
endinterface

// [core/kbrf_pm_map.sv]
// Program memory map decoder: vectors, mask ROM, reserved area
`include "kbrf_cfg.svh"
module kbrf_pm_map #(
  parameter logic [15:0] ROM_TOP = `KBRF_ROM_TOP
) (
  // Fetch side
  kbrf_pm_if.map pm
);
  // Classify the program address
  always_comb begin
    if (pm.pc < `KBRF_VEC_END) begin
      pm.kind = kbrf_pkg::KBRF_PM_VECTOR;
    end else if (pm.pc <= ROM_TOP) begin
      pm.kind = kbrf_pkg::KBRF_PM_ROM;
    end else begin
      pm.kind = kbrf_pkg::KBRF_PM_RESERVED;
    end
    pm.rom_hit = (pm.pc <= ROM_TOP);
  end
endmodule

// [test/kbrf_keys.sv]
// Keyboard side model: key switches and pull-ups on port 2 and port 3 lines
module kbrf_keys (
  // Key levels from the bench, low means pressed
  input  wire logic [7:0] key_p2,
  input  wire logic [3:0] key_p3,
  // Device side of port 2
  input  wire logic [7:0] p2_out,
  input  wire logic [7:0] p2_oe_n,
  // Resolved line levels
  output logic      [7:0] p2_line,
  output logic      [3:0] p3_line
);
  // Wired-AND: a released line floats high through its pull-up
  assign p2_line = key_p2 & (p2_oe_n | p2_out);
  // Low port 3 lines are only ever driven by keys
  assign p3_line = key_p3;
endmodule

// [test/keyboard_mcu_register_file_ports_tb.sv]
// Self-checking bench for the keyboard register file, map and ports
module keyboard_mcu_register_file_ports_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] ROM_TOP = 16'h0bff;  // Mid-size ROM variant
  // Stimulus
  logic clk_sys = 0, rst = 1, stop_recovery = 0, test_clock_enable = 1;
  logic reg_wr = 0, reg_short = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, key_p2 = 8'hff;
  logic [3:0] key_p3 = 4'hf;
  logic [15:0] fetch_pc = 16'h0000;
  // Observed
  logic [7:0] reg_rdata, reg_resolved, p0_oe_n, p1_oe_n, p2_in, p2_out, p2_oe_n;
  logic [3:0] p3_in, p3_out, irq;
  logic [1:0] fetch_kind;
  logic fetch_valid, tclk;
  int n_mismatch = 0, checks_done = 0;
  always #4 clk_sys = ~clk_sys;
  kbrf_core #(.ROM_TOP(ROM_TOP)) u_kbrf_core (.clk_sys(clk_sys), .rst(rst),
    .stop_recovery(stop_recovery), .test_clock_enable(test_clock_enable), .reg_wr(reg_wr),
    .reg_short(reg_short), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_resolved(reg_resolved), .fetch_pc(fetch_pc),
    .fetch_kind(fetch_kind), .fetch_valid(fetch_valid), .first_open_drain_port_oe_n(p0_oe_n),
    .second_open_drain_port_oe_n(p1_oe_n), .mixed_direction_port_in(p2_in),
    .mixed_direction_port_out(p2_out), .mixed_direction_port_oe_n(p2_oe_n),
    .port3_fixed_inputs(p3_in), .port3_fixed_outputs(p3_out),
    .external_interrupt_requests(irq), .test_clock_output(tclk));
  kbrf_keys u_kbrf_keys (.key_p2(key_p2), .key_p3(key_p3), .p2_out(p2_out),
    .p2_oe_n(p2_oe_n), .p2_line(p2_in), .p3_line(p3_in));
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe, always followed by an idle cycle
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_wr, reg_short, reg_addr, reg_wdata} = {1'b1, s, a, d};
    @(negedge clk_sys);
    reg_wr = 0;
  endtask
  // Present a read address; data is combinational
  task automatic at(input logic s, input logic [7:0] a);
    @(negedge clk_sys);
    {reg_short, reg_addr} = {s, a};
    #1;
  endtask
  task automatic t_reset;
    chk(p0_oe_n, 8'hff);
    chk(p1_oe_n, 8'hff);
    chk(p2_oe_n, 8'hff);
    chk({p3_out, irq}, 8'hf0);
    $display("test reset done");
  endtask
  task automatic t_ports;
    wr(0, 8'h00, 8'h0f);
    wr(0, 8'h01, 8'ha5);
    wr(0, 8'hf6, 8'h5f);
    wr(0, 8'h02, 8'h00);
    wr(0, 8'h03, 8'h5a);
    chk(p0_oe_n, 8'h0f);
    chk(p1_oe_n, 8'ha5);
    chk(p2_oe_n, 8'h5f);
    chk(p2_out[7] | p2_out[5], 1'b0);
    chk(p3_out, 4'h5);
    // Keys reach the reads only after the two synchroniser stages
    @(negedge clk_sys);
    {key_p2, key_p3} = {8'hb3, 4'h6};
    repeat (2) @(negedge clk_sys);
    at(0, 8'h02);
    chk(reg_rdata, 8'h13);
    chk(irq, 4'h0);
    at(0, 8'h03);
    chk(reg_rdata, 8'h56);
    @(negedge clk_sys);
    {key_p2, key_p3} = {8'hff, 4'hf};
    wr(0, 8'hf6, 8'hf0);
    chk(p2_oe_n, 8'hff);
    $display("test ports done");
  endtask
  task automatic t_regs;
    wr(0, 8'h04, 8'h11);
    wr(0, 8'hbf, 8'h22);
    wr(0, 8'hc0, 8'h33);
    wr(0, 8'hef, 8'h44);
    at(0, 8'h04);
    chk({reg_resolved, reg_rdata}, 16'h0411);
    at(0, 8'hbf);
    chk(reg_rdata, 8'h22);
    at(0, 8'hc0);
    chk(reg_rdata, 8'hff);
    at(0, 8'hef);
    chk(reg_rdata, 8'hff);
    $display("test regs done");
  endtask
  task automatic t_short;
    wr(0, 8'hfd, 8'h20);
    wr(1, 8'h05, 8'h77);
    at(1, 8'h05);
    chk({reg_resolved, reg_rdata}, 16'h2577);
    at(1, 8'h0f);
    chk(reg_resolved, 8'h2f);
    at(0, 8'h25);
    chk(reg_rdata, 8'h77);
    $display("test short done");
  endtask
  task automatic t_stop;
    @(negedge clk_sys);
    stop_recovery = 1;
    @(negedge clk_sys);
    stop_recovery = 0;
    at(0, 8'h04);
    chk(reg_rdata, 8'h11);
    at(0, 8'hfd);
    chk(reg_rdata, 8'h20);
    chk(p0_oe_n, 8'hff);
    $display("test stop done");
  endtask
  task automatic t_irq;
    logic [3:0] seen;
    int n;
    seen = 0;
    n = 0;
    wr(0, 8'hfb, 8'h01);
    key_p3 = 4'h0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      seen |= irq;
      n += (irq != 0);
    end
    @(negedge clk_sys);
    key_p3 = 4'hf;
    chk(seen, 4'h1);
    chk(n, 1);
    $display("test irq done");
  endtask
  task automatic t_fetch;
    logic [15:0] pcs [6];
    pcs = '{16'h0000, 16'h000b, 16'h000c, ROM_TOP, ROM_TOP + 16'h1, 16'hffff};
    foreach (pcs[i]) begin
      @(negedge clk_sys);
      fetch_pc = pcs[i];
      #1;
      chk({fetch_valid, fetch_kind}, {pcs[i] <= ROM_TOP, pcs[i] < 16'h000c ?
        kbrf_pkg::KBRF_PM_VECTOR : pcs[i] <= ROM_TOP ? kbrf_pkg::KBRF_PM_ROM :
        kbrf_pkg::KBRF_PM_RESERVED});
    end
    $display("test fetch done");
  endtask
  task automatic t_tclk;
    @(posedge clk_sys);
    #1;
    chk(tclk, 1'b1);
    @(negedge clk_sys);
    #1;
    chk(tclk, 1'b0);
    // Strap passes two flip-flops before it gates the clock
    @(negedge clk_sys);
    test_clock_enable = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(tclk, 1'b0);
    $display("test clock done");
  endtask
  // Verdict, shared with the watchdog
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence after a six-cycle reset
  initial begin
    repeat (6) @(negedge clk_sys);
    rst = 0;
    t_reset();
    t_ports();
    t_regs();
    t_short();
    t_stop();
    t_irq();
    t_fetch();
    t_tclk();
    report_and_stop();
  end
  // Hang guard, far beyond the roughly 70 cycles needed
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
